// ---- shared/stc_consts.svh ----
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// Register byte offsets
`define STC_OFS_CTRL 8'h00
`define STC_OFS_STAT 8'h04
`define STC_OFS_COUNT 8'h08
`define STC_OFS_LIMIT 8'h0C
`define STC_OFS_CAPT 8'h10
`define STC_OFS_IRQ_STAT 8'h14
`define STC_OFS_IRQ_MASK 8'h18

// Control word fields
`define STC_CTRL_W 13
`define STC_CTRL_TASK_LSB 0
`define STC_CTRL_TASK_MSB 2
`define STC_CTRL_EN_BIT 3
`define STC_CTRL_SRC_BIT 4
`define STC_CTRL_PRE_LSB 5
`define STC_CTRL_PRE_MSB 6
`define STC_CTRL_MODE_LSB 7
`define STC_CTRL_MODE_MSB 8

// Status word fields
`define STC_STAT_EVT_BIT 0
`define STC_STAT_WRAP_BIT 1

// Interrupt status and mask fields
`define STC_IRQ_W 3
`define STC_IRQ_EVT_BIT 0
`define STC_IRQ_WRAP_BIT 1
`define STC_IRQ_CAPT_BIT 2

// Highest valid event task number
`define STC_TASK_MAX 3'h4

// Prescaler terminal counts for divide by 1, 4, 16 and 64
`define STC_PRE_W 6
`define STC_PRE_DIV1 6'h00
`define STC_PRE_DIV4 6'h03
`define STC_PRE_DIV16 6'h0F
`define STC_PRE_DIV64 6'h3F

// Reset values
`define STC_CTRL_RST 13'h0000
`define STC_LIMIT_RST 16'hFFFF
`define STC_IRQ_MASK_RST 3'h0

`endif

// ---- shared/stc_pkg.sv ----
package stc_pkg;

   // Counter modes held in the control word
   typedef enum logic [1:0] {
      STC_MODE_FREE,
      STC_MODE_CAP_RISE,
      STC_MODE_CAP_FALL,
      STC_MODE_RSVD
   } stc_mode_e;

   // Wishbone address and data
   typedef logic [7:0] stc_addr_t;
   typedef logic [31:0] stc_data_t;

endpackage

// ---- design/stc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two flop synchroniser, one chain per bit
module stc_sync #(
   parameter int W = 2
) (
   input wire logic i_clk, // System clock
   input wire logic i_rst, // Async reset, active high
   input wire logic [W-1:0] i_async, // Pins from outside
   output logic [W-1:0] o_sync // Synchronised levels
);

   // Elaboration check on width
   if (W < 1) begin : g_bad_w
      $error("stc_sync: W must be at least 1");
   end

   genvar g;
   for (g = 0; g < W; g++) begin : g_bit
      logic meta_reg; // First stage, read only by second stage
      logic sync_reg; // Second stage, the only one logic may read
      // Two flops per bit
      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
         end else begin
            meta_reg <= i_async[g];
            sync_reg <= meta_reg;
         end
      end
      // Each output bit has exactly one driver
      assign o_sync[g] = sync_reg;
   end

endmodule

`default_nettype wire

// ---- design/stc_timer.sv ----
// What this block does
// (R1) Sixteen bit counter, counts up only
// (R2) Source bit picks internal or external clock
// (R3) Prescale divides internal clock 1/4/16/64
// (R4) External clock kept under its maximum rate
// (R5) Enable bit stops or runs counting
// (R6) Task field schedules none or task 1-4
// (R7) Free mode: event flag on each wrap
// (R8) Mode 1: rising capture edge latches count
// (R9) Mode 2: falling capture edge latches count
// (R10) Capture modes: keep counting, no wrap event
// (R11) Wrap point anywhere in 16-bit range
// (R12) Event flag auto-clears with task, else read
// (R13) Wrap flag sets always, clears on read
// (R14) Count readable and writable, immediate effect
// (R15) Wrap limit register sets wrap value
// (R16) Limit then zero; mode 3 acts free
// (R17) Pins synchronised, each edge acted once
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "stc_consts.svh"

module stc_timer #(
   parameter int CNT_W = 16
) (
   input wire logic i_clk, // 125 MHz system clock
   input wire logic i_rst, // Async reset, active high
   input wire logic i_wb_cyc, // Wishbone cycle
   input wire logic i_wb_stb, // Wishbone strobe
   input wire logic i_wb_we, // Wishbone write enable
   input wire stc_pkg::stc_addr_t i_wb_adr, // Wishbone byte address
   input wire logic [3:0] i_wb_sel, // Wishbone byte lanes
   input wire stc_pkg::stc_data_t i_wb_dat, // Wishbone write data
   output stc_pkg::stc_data_t o_wb_dat, // Wishbone read data
   output logic o_wb_ack, // Wishbone acknowledge
   input wire logic i_capture_input, // Capture pin
   input wire logic i_external_clock_input, // External count clock pin
   output logic o_irq, // Level interrupt
   output logic o_task_req, // One-cycle task schedule pulse
   output logic [2:0] o_task_num // Task number with the pulse
);
   import stc_pkg::*;

   // Elaboration check on counter width
   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_w
      $error("stc_timer: CNT_W must lie in 2..32");
   end

   // Merge write data into a register by byte lane
   function automatic logic [31:0] wb_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] sel
   );
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Task field names a real task
   function automatic logic task_valid(input logic [2:0] t);
      return (t != 3'h0) && (t <= `STC_TASK_MAX);
   endfunction

   // Register state
   logic [`STC_CTRL_W-1:0] ctrl_reg; // Control word
   logic [CNT_W-1:0] count_reg; // Present count value
   logic [CNT_W-1:0] limit_reg; // Wrap limit value
   logic [CNT_W-1:0] capt_reg; // Capture holding value
   logic evt_flag_reg; // Timer event flag
   logic wrap_flag_reg; // Wrap flag
   logic [`STC_IRQ_W-1:0] irq_stat_reg; // Sticky interrupt status
   logic [`STC_IRQ_W-1:0] irq_mask_reg; // Interrupt mask
   logic [`STC_PRE_W-1:0] pre_reg; // Prescaler count

   // Control fields
   logic [2:0] task_sel; // Event task select
   logic enable; // Counting enable
   logic src_ext; // External clock chosen
   logic [1:0] pre_sel; // Prescale field
   stc_mode_e mode; // Timer mode
   assign task_sel = ctrl_reg[`STC_CTRL_TASK_MSB:`STC_CTRL_TASK_LSB];
   assign enable = ctrl_reg[`STC_CTRL_EN_BIT];
   assign src_ext = ctrl_reg[`STC_CTRL_SRC_BIT];
   assign pre_sel = ctrl_reg[`STC_CTRL_PRE_MSB:`STC_CTRL_PRE_LSB];
   assign mode = stc_mode_e'(ctrl_reg[`STC_CTRL_MODE_MSB:`STC_CTRL_MODE_LSB]);

   // Bus decode
   logic bus_req; // New request this cycle
   logic wr_req; // Write taken this cycle
   logic rd_req; // Read taken this cycle
   logic [31:0] wdat; // Lane-merged write data
   assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr_req = bus_req && i_wb_we;
   assign rd_req = bus_req && !i_wb_we;

   // Pin synchronisers
   logic [1:0] pin_sync; // Bit 0 capture, bit 1 external clock
   logic [1:0] pin_last_reg; // Previous synchronised levels
   stc_sync #(.W(2)) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_external_clock_input, i_capture_input}),
      .o_sync(pin_sync)
   );

   // Edge history for synchronised pins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_last_reg <= 2'h0;
      end else begin
         pin_last_reg <= pin_sync; // [R17]
      end
   end

   // Single-cycle edge strobes
   logic cap_rise; // Capture pin rose
   logic cap_fall; // Capture pin fell
   logic ext_rise; // External clock rose
   assign cap_rise = pin_sync[0] && !pin_last_reg[0]; // [R17]
   assign cap_fall = !pin_sync[0] && pin_last_reg[0]; // [R17]
   assign ext_rise = pin_sync[1] && !pin_last_reg[1]; // [R17]

   // Prescaler terminal count from field
   logic [`STC_PRE_W-1:0] pre_term; // Terminal count
   always_comb begin
      case (pre_sel)
         2'h0: pre_term = `STC_PRE_DIV1; // [R3]
         2'h1: pre_term = `STC_PRE_DIV4; // [R3]
         2'h2: pre_term = `STC_PRE_DIV16; // [R3]
         default: pre_term = `STC_PRE_DIV64; // [R3]
      endcase
   end

   // Prescaler runs only while enabled on internal clock
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_reg <= '0;
      end else if (!enable || src_ext || pre_reg >= pre_term) begin
         pre_reg <= '0; // [R3]
      end else begin
         pre_reg <= pre_reg + 1'b1;
      end
   end

   // Count tick from chosen source
   logic tick; // Counter advances
   logic wrap; // Counter wraps on this tick
   // External rate must stay under its ceiling to be seen [R4]
   assign tick = enable && (src_ext ? ext_rise : (pre_reg >= pre_term)); // [R2] [R5]
   assign wrap = tick && ((count_reg == limit_reg) || (&count_reg)); // [R11] [R16]

   // Capture strobe by mode
   logic cap_evt; // Capture taken
   assign cap_evt = enable && (((mode == STC_MODE_CAP_RISE) && cap_rise) // [R8]
      || ((mode == STC_MODE_CAP_FALL) && cap_fall)); // [R9]

   // Event flag cause per mode
   logic cap_mode; // Capture modes selected
   logic evt_set; // Event flag sets
   assign cap_mode = (mode == STC_MODE_CAP_RISE) || (mode == STC_MODE_CAP_FALL);
   assign evt_set = cap_mode ? cap_evt : wrap; // [R7] [R10] [R16]

   // Status word read this cycle
   logic stat_rd; // Status read taken
   assign stat_rd = rd_req && (i_wb_adr == `STC_OFS_STAT);

   // Merged write data for the addressed register
   always_comb begin
      case (i_wb_adr)
         `STC_OFS_CTRL: wdat = wb_merge(32'(ctrl_reg), i_wb_dat, i_wb_sel);
         `STC_OFS_COUNT: wdat = wb_merge(32'(count_reg), i_wb_dat, i_wb_sel);
         `STC_OFS_LIMIT: wdat = wb_merge(32'(limit_reg), i_wb_dat, i_wb_sel);
         `STC_OFS_CAPT: wdat = wb_merge(32'(capt_reg), i_wb_dat, i_wb_sel);
         `STC_OFS_IRQ_MASK: wdat = wb_merge(32'(irq_mask_reg), i_wb_dat, i_wb_sel);
         default: wdat = i_wb_dat & {{24{1'b0}}, {8{i_wb_sel[0]}}};
      endcase
   end

   // Control word
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg <= `STC_CTRL_RST;
      end else if (wr_req && i_wb_adr == `STC_OFS_CTRL) begin
         ctrl_reg <= wdat[`STC_CTRL_W-1:0];
      end
   end

   // Present count: software write wins over a tick
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count_reg <= '0;
      end else if (wr_req && i_wb_adr == `STC_OFS_COUNT) begin
         count_reg <= wdat[CNT_W-1:0]; // [R14]
      end else if (wrap) begin
         count_reg <= '0; // [R16]
      end else if (tick) begin
         count_reg <= count_reg + 1'b1; // [R1]
      end
   end

   // Wrap limit
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         limit_reg <= CNT_W'(`STC_LIMIT_RST);
      end else if (wr_req && i_wb_adr == `STC_OFS_LIMIT) begin
         limit_reg <= wdat[CNT_W-1:0]; // [R15] [R11]
      end
   end

   // Capture holding value; a capture beats a software write
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         capt_reg <= '0;
      end else if (cap_evt) begin
         capt_reg <= count_reg; // [R8] [R9]
      end else if (wr_req && i_wb_adr == `STC_OFS_CAPT) begin
         capt_reg <= wdat[CNT_W-1:0];
      end
   end

   // Timer event flag: set wins over either clear
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         evt_flag_reg <= 1'b0;
      end else if (evt_set) begin
         evt_flag_reg <= 1'b1; // [R7] [R8] [R9]
      end else if (task_valid(task_sel)) begin
         evt_flag_reg <= 1'b0; // [R12]
      end else if (stat_rd) begin
         evt_flag_reg <= 1'b0; // [R12]
      end
   end

   // Wrap flag: every mode, cleared by status read
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wrap_flag_reg <= 1'b0;
      end else if (wrap) begin
         wrap_flag_reg <= 1'b1; // [R13]
      end else if (stat_rd) begin
         wrap_flag_reg <= 1'b0; // [R13]
      end
   end

   // Task schedule pulse with the event
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_task_req <= 1'b0;
         o_task_num <= 3'h0;
      end else begin
         o_task_req <= evt_set && task_valid(task_sel); // [R6]
         o_task_num <= (evt_set && task_valid(task_sel)) ? task_sel : 3'h0; // [R6]
      end
   end

   // Interrupt event vector
   logic [`STC_IRQ_W-1:0] irq_evt; // Raw events
   always_comb begin
      irq_evt = '0;
      irq_evt[`STC_IRQ_EVT_BIT] = evt_set;
      irq_evt[`STC_IRQ_WRAP_BIT] = wrap;
      irq_evt[`STC_IRQ_CAPT_BIT] = cap_evt;
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_reg <= '0;
      end else if (wr_req && i_wb_adr == `STC_OFS_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~wdat[`STC_IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_evt;
      end
   end

   // Interrupt mask
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask_reg <= `STC_IRQ_MASK_RST;
      end else if (wr_req && i_wb_adr == `STC_OFS_IRQ_MASK) begin
         irq_mask_reg <= wdat[`STC_IRQ_W-1:0];
      end
   end

   // Interrupt line from masked status
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Read mux, unmapped reads return zero
   logic [31:0] rdat; // Read value
   always_comb begin
      rdat = '0;
      case (i_wb_adr)
         `STC_OFS_CTRL: rdat = 32'(ctrl_reg);
         `STC_OFS_STAT: begin
            rdat[`STC_STAT_EVT_BIT] = evt_flag_reg;
            rdat[`STC_STAT_WRAP_BIT] = wrap_flag_reg;
         end
         `STC_OFS_COUNT: rdat = 32'(count_reg); // [R14]
         `STC_OFS_LIMIT: rdat = 32'(limit_reg);
         `STC_OFS_CAPT: rdat = 32'(capt_reg);
         `STC_OFS_IRQ_STAT: rdat = 32'(irq_stat_reg);
         `STC_OFS_IRQ_MASK: rdat = 32'(irq_mask_reg);
         default: rdat = '0;
      endcase
   end

   // Acknowledge one cycle after request, dropped next cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end else begin
         o_wb_ack <= bus_req;
         o_wb_dat <= rd_req ? rdat : 32'h00000000;
      end
   end

endmodule

`default_nettype wire

// ---- test/stc_timer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.svh"

// Port-level checks on bus answers, task pulses and the interrupt
module stc_timer_chk #(
   parameter int CNT_W = 16
) (
   input wire logic i_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic i_wb_cyc, // Cycle
   input wire logic i_wb_stb, // Strobe
   input wire logic i_wb_we, // Write
   input wire stc_pkg::stc_addr_t i_wb_adr, // Address
   input wire logic [3:0] i_wb_sel, // Lanes
   input wire stc_pkg::stc_data_t i_wb_dat, // Write data
   input wire stc_pkg::stc_data_t o_wb_dat, // Read data
   input wire logic o_wb_ack, // Ack
   input wire logic i_capture_input, // Capture pin
   input wire logic i_external_clock_input, // Count clock pin
   input wire logic o_irq, // Interrupt
   input wire logic o_task_req, // Task pulse
   input wire logic [2:0] o_task_num // Task number
);
   import stc_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ack_pulse_a: assert property (
      o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
   ack_timing_a: assert property (
      (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack) else $error("ack late");
   ack_cause_a: assert property (
      $rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
   data_idle_a: assert property (
      !o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data outside ack");
   task_code_a: assert property (
      o_task_req |-> o_task_num inside {[3'h1:3'h4]}) else $error("bad task number");
   task_idle_a: assert property (
      !o_task_req |-> o_task_num == 3'h0) else $error("task number without pulse");
   mask_off_a: assert property (
      (o_wb_ack && i_wb_we && i_wb_adr == `STC_OFS_IRQ_MASK && i_wb_sel[0]
       && i_wb_dat[2:0] == 3'h0) |=> !o_irq) else $error("irq with mask clear");
   unmapped_zero_a: assert property (
      (o_wb_ack && !i_wb_we && i_wb_adr == 8'h1C) |-> o_wb_dat == 32'h0)
      else $error("unmapped read not zero");
   stat_width_a: assert property (
      (o_wb_ack && !i_wb_we && i_wb_adr == `STC_OFS_STAT) |-> o_wb_dat[31:2] == 30'h0)
      else $error("status wider than two bits");
   count_width_a: assert property (
      (o_wb_ack && !i_wb_we && i_wb_adr == `STC_OFS_COUNT) |-> (o_wb_dat >> CNT_W) == 32'h0)
      else $error("count wider than counter");
endmodule

bind stc_timer stc_timer_chk #(.CNT_W(CNT_W)) i_stc_timer_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_capture_input(i_capture_input),
   .i_external_clock_input(i_external_clock_input), .o_irq(o_irq),
   .o_task_req(o_task_req), .o_task_num(o_task_num));
`default_nettype wire

// ---- test/stc_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Outside world driving the capture pin and the external count clock
module stc_pins_model (
   input wire logic i_clk, // Clock
   output logic o_capture_input, // Capture pin level
   output logic o_external_clock_input // External count clock
);
   // Pins idle low, count clock stands still between bursts
   initial begin
      o_capture_input = 1'b0;
      o_external_clock_input = 1'b0;
   end
   // Move the capture pin to a new level after an edge
   task automatic set_capture(input logic lvl);
      @(posedge i_clk);
      o_capture_input <= lvl;
   endtask
   // Pulse burst; a half period of 105 clocks or more stays under the rate limit
   task automatic ext_pulses(input int n, input int half);
      repeat (n) begin
         @(posedge i_clk);
         o_external_clock_input <= 1'b1;
         repeat (half) @(posedge i_clk);
         o_external_clock_input <= 1'b0;
         repeat (half) @(posedge i_clk);
      end
   endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

// Self-checking bench: register model against the timer
module testbench;
   import stc_pkg::*;
   logic i_clk, i_rst, cyc, stb, we, ack, irq, treq, cap, ext;
   logic [3:0] sel;
   logic [2:0] tnum, got;
   stc_addr_t adr;
   stc_data_t wdat, q, o_wb_dat, c;
   int n_errors = 0;
   int n_compared = 0;
   int mdl[int]; // Expected control and limit contents
   int p, t, m, e, lim, k;
   bit f;
   stc_timer i_stc_timer (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
      .o_wb_ack(ack), .i_capture_input(cap), .i_external_clock_input(ext), .o_irq(irq),
      .o_task_req(treq), .o_task_num(tnum));
   stc_pins_model i_stc_pins_model (.i_clk(i_clk), .o_capture_input(cap),
      .o_external_clock_input(ext));
   // Free-running clock
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Print counts and verdict, then stop
   task automatic final_report;
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One classic cycle; data taken at the ack edge
   task automatic wb(input logic w, input stc_addr_t a, input stc_data_t d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1) begin
         n_errors++;
         final_report();
      end
      q = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge i_clk);
   endtask
   // Write and update the model
   task automatic wr(input stc_addr_t a, input stc_data_t d);
      wb(1'b1, a, d);
      if (a == 8'h00) mdl[0] = d & 32'h1FFF;
      if (a == 8'h0C) mdl[12] = d & 32'hFFFF;
   endtask
   // Wait a bounded time for a task pulse
   task automatic wait_task;
      f = 1'b0;
      repeat (20) begin
         @(posedge i_clk);
         if (treq === 1'b1 && !f) begin
            f = 1'b1;
            got = tnum;
         end
      end
   endtask
   // Main sequence
   initial begin
      i_rst = 1'b1;
      {cyc, stb, we, adr, sel, wdat} = '0;
      mdl[0] = 0;
      mdl[12] = 32'hFFFF;
      void'($urandom(32'hE995));
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      // Reset values, unmapped address last
      for (p = 0; p < 8; p++) begin
         wb(1'b0, 8'(p * 4), 32'h0);
         `CHK(q, (p == 3) ? 32'hFFFF : 32'h0)
      end
      $display("reset values done");
      // Read back of control, limit and count while stopped
      repeat (4) begin
         wr(8'h00, $urandom & 32'hFFFFFFF7);
         wb(1'b0, 8'h00, 32'h0);
         `CHK(q, 32'(mdl[0]))
         wr(8'h0C, $urandom);
         wb(1'b0, 8'h0C, 32'h0);
         `CHK(q, 32'(mdl[12]))
         c = $urandom;
         wr(8'h08, c);
         wb(1'b0, 8'h08, 32'h0);
         `CHK(q, c & 32'hFFFF)
      end
      $display("register access done");
      // Prescaler: 257 clocks between enable and disable
      for (p = 0; p < 4; p++) begin
         wr(8'h0C, 32'hFFFF);
         wr(8'h08, 32'h0);
         wr(8'h00, 32'(8 | (p << 5)));
         repeat (254) @(posedge i_clk);
         wr(8'h00, 32'h0);
         wb(1'b0, 8'h08, 32'h0);
         e = 256 >> (2 * p);
         `CHK((int'(q) - e) inside {[-1:1]}, 1'b1)
      end
      c = q;
      repeat (20) @(posedge i_clk);
      wb(1'b0, 8'h08, 32'h0);
      `CHK(q, c)
      $display("prescaler done");
      // External clock ignores the prescaler, and stops with enable
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h8 | 32'h10 | 32'h60);
      i_stc_pins_model.ext_pulses(5, 105 + $urandom % 40);
      repeat (4) @(posedge i_clk);
      wr(8'h00, 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      `CHK(q, 32'h5)
      i_stc_pins_model.ext_pulses(2, 110);
      wb(1'b0, 8'h08, 32'h0);
      `CHK(q, 32'h5)
      $display("external clock done");
      // Free running and reserved mode: wrap flags, read clear, interrupt
      for (m = 0; m < 4; m += 3) begin
         lim = 3 + $urandom % 5;
         wr(8'h0C, lim);
         wr(8'h08, 32'h0);
         wr(8'h18, 32'h3);
         wr(8'h00, 32'(8 | (m << 7)));
         repeat (40) @(posedge i_clk);
         `CHK(irq, 1'b1)
         wr(8'h00, 32'h0);
         wb(1'b0, 8'h08, 32'h0);
         `CHK(q <= 32'(lim), 1'b1)
         wb(1'b0, 8'h04, 32'h0);
         `CHK(q, 32'h3)
         wb(1'b0, 8'h04, 32'h0);
         `CHK(q, 32'h0)
         wr(8'h14, 32'h3);
         wr(8'h18, 32'h0);
         `CHK(irq, 1'b0)
      end
      $display("free running done");
      // Capture modes: wrong edge ignored, right edge captures and schedules
      for (t = 1; t <= 4; t++) begin
         m = (t % 2) ? 1 : 2;
         i_stc_pins_model.set_capture(m == 1);
         repeat (6) @(posedge i_clk);
         wr(8'h0C, 32'hFFFF);
         wr(8'h08, 32'h0);
         wr(8'h18, 32'h4);
         wr(8'h00, 32'(t | 8 | (m << 7)));
         i_stc_pins_model.set_capture(m != 1);
         wait_task();
         `CHK(f, 1'b0)
         i_stc_pins_model.set_capture(m == 1);
         wait_task();
         `CHK(f, 1'b1)
         `CHK(got, 3'(t))
         `CHK(irq, 1'b1)
         wb(1'b0, 8'h10, 32'h0);
         c = q;
         wb(1'b0, 8'h08, 32'h0);
         `CHK(c != 32'h0 && c < q, 1'b1)
         wb(1'b0, 8'h04, 32'h0);
         `CHK(q, 32'h0)
         wr(8'h14, 32'h4);
         @(posedge i_clk);
         `CHK(irq, 1'b0)
      end
      $display("capture done");
      // Capture mode with a small limit and no task: wrap flag only, no event
      wr(8'h0C, 32'h3);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h88);
      wait_task();
      `CHK(f, 1'b0)
      wr(8'h00, 32'h0);
      wb(1'b0, 8'h04, 32'h0);
      `CHK(q, 32'h2)
      $display("capture wrap done");
      final_report();
   end
endmodule
`default_nettype wire
